//--- design/lfsc_cfg.svh
// constants for the line feed state control block: offsets, fields, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef LFSC_CFG_SVH
`define LFSC_CFG_SVH

// register offsets on the serial port (7-bit address)
`define LFSC_OFF_LINE_STATE 7'h40
`define LFSC_OFF_CURRENT_CAP 7'h47
`define LFSC_OFF_OPEN_VOLT 7'h48
`define LFSC_OFF_COMMON_VOLT 7'h49

// field positions
`define LFSC_LS_FIELD_LSB 0
`define LFSC_LS_FIELD_MSB 2
`define LFSC_LS_APPLIED_LSB 4
`define LFSC_LS_APPLIED_MSB 6

// reset values: 20 mA is code 0, 48 V is code 32, 3 V is code 2
`define LFSC_RST_LINE_STATE 3'h0
`define LFSC_RST_CURRENT_CAP 3'h0
`define LFSC_RST_OPEN_VOLT 6'h20
`define LFSC_RST_COMMON_VOLT 6'h02

// serial frame: command byte then data byte, bit 7 of the command set for a read
`define LFSC_SPI_READ_BIT 7
`define LFSC_SPI_CMD_BITS 5'h08
`define LFSC_SPI_FRAME_BITS 5'h10

`endif

//--- design/lfsc_pkg.sv
// types shared by the line feed state control design
// assumes lfsc_cfg.svh is on the include path
package lfsc_pkg;
	`include "lfsc_cfg.svh"

	typedef enum logic [2:0] {
		LFSC_OPEN,
		LFSC_FWD_ACTIVE,
		LFSC_FWD_OHT,
		LFSC_TIP_OPEN,
		LFSC_RINGING,
		LFSC_REV_ACTIVE,
		LFSC_REV_OHT,
		LFSC_RING_OPEN
	} lfsc_line_state_e;

	typedef logic [7:0] lfsc_byte_t;
	typedef logic [6:0] lfsc_addr_t;
endpackage : lfsc_pkg

//--- design/lfsc_spi_slave.sv
// serial register port: command byte (read flag, 7-bit address) then data byte
// assumes sclk idles low, data sampled on rising sclk and changed on falling sclk;
// pins are oversampled by mclk, so sclk must stay below about mclk/8
`timescale 1ns/1ns
`include "lfsc_cfg.svh"
module lfsc_spi_slave
	import lfsc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// serial pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// register side
	output lfsc_pkg::lfsc_addr_t addr_o,
	output lfsc_pkg::lfsc_byte_t wdata_o,
	output logic wr_o,
	input wire lfsc_pkg::lfsc_byte_t rdata_i
);
	import lfsc_pkg::*;

	// pins order: sclk, cs_n, mosi; first stage feeds only the second
	logic [2:0] s1_reg, s2_reg, s3_reg;
	logic [4:0] cnt_reg, cnt_next;
	lfsc_byte_t rx_reg, rx_next, cmd_reg, cmd_next, tx_reg, tx_next;
	logic miso_reg, miso_next, oe_reg, oe_next, wr_reg, wr_next;
	logic rise, fall, cs_act;

	assign rise = s2_reg[2] & ~s3_reg[2];
	assign fall = ~s2_reg[2] & s3_reg[2];
	assign cs_act = ~s2_reg[1];

	always_comb begin
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		cmd_next = cmd_reg;
		tx_next = tx_reg;
		miso_next = miso_reg;
		wr_next = 1'b0;
		oe_next = cs_act;
		if (!cs_act) begin
			// a dropped select abandons a partial frame
			cnt_next = 5'h00;
		end else if (rise && cnt_reg < `LFSC_SPI_FRAME_BITS) begin
			rx_next = {rx_reg[6:0], s2_reg[0]};
			cnt_next = cnt_reg + 5'h01;
			if (cnt_reg == `LFSC_SPI_CMD_BITS - 5'h01) begin
				cmd_next = {rx_reg[6:0], s2_reg[0]};
			end
			if (cnt_reg == `LFSC_SPI_FRAME_BITS - 5'h01) begin
				wr_next = ~cmd_reg[`LFSC_SPI_READ_BIT];
			end
		end else if (fall && cnt_reg == `LFSC_SPI_CMD_BITS) begin
			// load on the first data fall, once cmd_reg holds this frame's address
			miso_next = rdata_i[7];
			tx_next = {rdata_i[6:0], 1'b0};
		end else if (fall && cnt_reg > `LFSC_SPI_CMD_BITS) begin
			miso_next = tx_reg[7];
			tx_next = {tx_reg[6:0], 1'b0};
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= 3'h2;
			s2_reg <= 3'h2;
			s3_reg <= 3'h2;
			cnt_reg <= 5'h00;
			rx_reg <= 8'h00;
			cmd_reg <= 8'h00;
			tx_reg <= 8'h00;
			miso_reg <= 1'b0;
			oe_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			s1_reg <= {sclk_i, cs_n_i, mosi_i};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
			cmd_reg <= cmd_next;
			tx_reg <= tx_next;
			miso_reg <= miso_next;
			oe_reg <= oe_next;
			wr_reg <= wr_next;
		end
	end

	assign miso_o = miso_reg;
	assign miso_oe_o = oe_reg;
	assign wr_o = wr_reg;
	assign addr_o = cmd_reg[6:0];
	assign wdata_o = rx_reg;
endmodule : lfsc_spi_slave

//--- design/lfsc_top.sv
// line feed state control: dc feed settings, eight line states, power alarm open
// assumes external transistors obey the drive enables and a comparator flags overpower
//
// Functional notes
// R1 - current cap is a three-bit code, 20 mA to 41 mA in 3 mA steps.
// R2 - open line voltage is a six-bit code, 0 to 94.5 V in 1.5 V steps.
// R3 - common offset voltage is six bits, headroom for the positive-most lead.
// R4 - settings hold 20 mA, 48 V, 3 V until software programs them first.
// R5 - eight line states, chosen by the written line state field unless auto-open on overpower forces the open state.
// R6 - open state drops every drive current; both leads undriven.
// R7 - block can force the open state itself on transistor overpower.
// R8 - forward and reverse active drive the line, audio paths powered down.
// R9 - on-hook transmission states power the audio paths up.
// R10 - tip open removes tip drive, keeps ring fed.
// R11 - ring open removes ring drive, keeps tip fed.
// R12 - ringing state drives the ringing waveform onto the line.
// R13 - field codes: 0 open,1 fa,2 fo,3 tip open,4 ring,5 ra,6 ro,7 ring open.
// R14 - overpower sets alarm flag, interrupt if enabled, open only if auto-open set.
// R15 - codes are linear: cap = 20 mA + 3 mA * code, voltages = 1.5 V * code.
// R16 - a written line state reaches the drive outputs one clock after the write.
`timescale 1ns/1ns
`include "lfsc_cfg.svh"
module lfsc_top
	import lfsc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// serial register port
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// power alarm pins
	input wire logic power_over_i,
	input wire logic auto_open_enable_i,
	input wire logic alarm_irq_enable_i,
	input wire logic alarm_clear_i,
	output logic power_alarm_o,
	output logic alarm_irq_o,
	// line drive controls
	output logic tip_drive_o,
	output logic ring_drive_o,
	output logic ringing_drive_o,
	output logic reverse_polarity_o,
	output logic audio_power_o,
	// dc feed settings
	output logic [2:0] loop_current_cap_o,
	output logic [5:0] open_line_voltage_o,
	output logic [5:0] common_offset_voltage_o
);
	import lfsc_pkg::*;

	logic rst_s1_reg, rst_n;
	// pins order: power_over, auto_open, irq_enable, alarm_clear
	logic [3:0] pin_s1_reg, pin_s2_reg;
	logic over_s, auto_s, irq_en_s, clear_s;

	lfsc_addr_t addr;
	lfsc_byte_t wdata, rdata;
	logic wr;

	lfsc_line_state_e field_reg, field_next, applied_reg, applied_next;
	logic [2:0] cap_reg, cap_next;
	logic [5:0] open_reg, open_next, common_reg, common_next;
	logic alarm_reg, alarm_next, irq_reg, irq_next;
	logic tip_reg, tip_next, ring_reg, ring_next, rng_reg, rng_next;
	logic rev_reg, rev_next, audio_reg, audio_next;

	// reset release through two flops
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= 4'h0;
			pin_s2_reg <= 4'h0;
		end else begin
			pin_s1_reg <= {power_over_i, auto_open_enable_i, alarm_irq_enable_i, alarm_clear_i};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign {over_s, auto_s, irq_en_s, clear_s} = pin_s2_reg;

	lfsc_spi_slave u_spi (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.mosi_i(mosi_i),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o),
		.addr_o(addr),
		.wdata_o(wdata),
		.wr_o(wr),
		.rdata_i(rdata)
	);

	// read mux; unmapped addresses and unused upper bits read as zero
	always_comb begin
		rdata = 8'h00;
		unique case (addr)
			`LFSC_OFF_LINE_STATE: begin
				rdata[`LFSC_LS_FIELD_MSB:`LFSC_LS_FIELD_LSB] = field_reg; // [R5]
				rdata[`LFSC_LS_APPLIED_MSB:`LFSC_LS_APPLIED_LSB] = applied_reg; // [R16]
			end
			`LFSC_OFF_CURRENT_CAP: rdata = {5'h00, cap_reg}; // [R1]
			`LFSC_OFF_OPEN_VOLT: rdata = {2'h0, open_reg}; // [R2]
			`LFSC_OFF_COMMON_VOLT: rdata = {2'h0, common_reg}; // [R3]
			default: rdata = 8'h00;
		endcase
	end

	// register writes; the alarm open overrides a write in the same cycle
	always_comb begin
		field_next = field_reg;
		cap_next = cap_reg;
		open_next = open_reg;
		common_next = common_reg;
		if (wr) begin
			unique case (addr)
				`LFSC_OFF_LINE_STATE: begin
					field_next = lfsc_line_state_e'(
						wdata[`LFSC_LS_FIELD_MSB:`LFSC_LS_FIELD_LSB]); // [R5]
				end
				`LFSC_OFF_CURRENT_CAP: cap_next = wdata[2:0]; // [R1] [R15]
				`LFSC_OFF_OPEN_VOLT: open_next = wdata[5:0]; // [R2] [R15]
				`LFSC_OFF_COMMON_VOLT: common_next = wdata[5:0]; // [R3]
				default: field_next = field_reg;
			endcase
		end
		if (over_s && auto_s) begin
			field_next = LFSC_OPEN; // [R7] [R14]
		end
	end

	// power alarm: sticky flag with its interrupt copy
	always_comb begin
		// alarm set wins over a clear in the same cycle
		alarm_next = over_s | (alarm_reg & ~clear_s); // [R14]
		irq_next = alarm_next & irq_en_s; // [R14]
	end

	// state decode from the stored field, registered so outputs follow one edge later
	always_comb begin
		applied_next = field_reg; // [R16]
		tip_next = 1'b0;
		ring_next = 1'b0;
		rng_next = 1'b0;
		rev_next = 1'b0;
		audio_next = 1'b0;
		unique case (field_reg) // [R13]
			LFSC_OPEN: tip_next = 1'b0; // [R6]
			LFSC_FWD_ACTIVE: {tip_next, ring_next} = 2'h3; // [R8]
			LFSC_FWD_OHT: {tip_next, ring_next, audio_next} = 3'h7; // [R9]
			LFSC_TIP_OPEN: ring_next = 1'b1; // [R10]
			LFSC_RINGING: {tip_next, ring_next, rng_next} = 3'h7; // [R12]
			LFSC_REV_ACTIVE: {tip_next, ring_next, rev_next} = 3'h7; // [R8]
			LFSC_REV_OHT: {tip_next, ring_next, rev_next, audio_next} = 4'hF; // [R9]
			LFSC_RING_OPEN: tip_next = 1'b1; // [R11]
		endcase
	end

	// register bank
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			field_reg <= lfsc_line_state_e'(`LFSC_RST_LINE_STATE);
			cap_reg <= `LFSC_RST_CURRENT_CAP; // [R4]
			open_reg <= `LFSC_RST_OPEN_VOLT; // [R4]
			common_reg <= `LFSC_RST_COMMON_VOLT; // [R4]
		end else begin
			field_reg <= field_next;
			cap_reg <= cap_next;
			open_reg <= open_next;
			common_reg <= common_next;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			alarm_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			alarm_reg <= alarm_next;
			irq_reg <= irq_next;
		end
	end

	// drive outputs; reset leaves both leads undriven until software picks a state
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			applied_reg <= lfsc_line_state_e'(`LFSC_RST_LINE_STATE);
			tip_reg <= 1'b0;
			ring_reg <= 1'b0;
			rng_reg <= 1'b0;
			rev_reg <= 1'b0;
			audio_reg <= 1'b0;
		end else begin
			applied_reg <= applied_next;
			tip_reg <= tip_next;
			ring_reg <= ring_next;
			rng_reg <= rng_next;
			rev_reg <= rev_next;
			audio_reg <= audio_next;
		end
	end

	assign power_alarm_o = alarm_reg;
	assign alarm_irq_o = irq_reg;
	assign tip_drive_o = tip_reg;
	assign ring_drive_o = ring_reg;
	assign ringing_drive_o = rng_reg;
	assign reverse_polarity_o = rev_reg;
	assign audio_power_o = audio_reg;
	assign loop_current_cap_o = cap_reg;
	assign open_line_voltage_o = open_reg;
	assign common_offset_voltage_o = common_reg;
endmodule : lfsc_top

//--- verification/lfsc_top_chk.sv
// checker for the line feed top: drive decode, power alarm, settings hold
// assumes one clock domain; sees only top module ports
`timescale 1ns/1ns
module lfsc_top_chk (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// pins
	input wire logic cs_n_i,
	input wire logic power_over_i,
	input wire logic auto_open_enable_i,
	input wire logic alarm_irq_enable_i,
	// outputs
	input wire logic power_alarm_o,
	input wire logic alarm_irq_o,
	input wire logic tip_drive_o,
	input wire logic ring_drive_o,
	input wire logic ringing_drive_o,
	input wire logic reverse_polarity_o,
	input wire logic audio_power_o,
	input wire logic [2:0] loop_current_cap_o,
	input wire logic [5:0] open_line_voltage_o,
	input wire logic [5:0] common_offset_voltage_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire logic fed = tip_drive_o && ring_drive_o;
	a_open_leads: assert property (
		!fed |-> !ringing_drive_o && !reverse_polarity_o && !audio_power_o)
		else $error("open lead decode wrong");
	a_audio_oht: assert property (
		audio_power_o |-> fed && !ringing_drive_o) else $error("audio decode wrong");
	a_ringing_feed: assert property (
		ringing_drive_o |-> fed && !audio_power_o) else $error("ringing decode wrong");
	a_reverse_feed: assert property (
		reverse_polarity_o |-> fed && !ringing_drive_o) else $error("reverse decode wrong");
	a_auto_open: assert property (
		$rose(power_alarm_o) && auto_open_enable_i |-> ##[1:2] !tip_drive_o && !ring_drive_o)
		else $error("no auto open");
	a_alarm_sets: assert property (
		$rose(power_over_i) |-> ##[2:6] power_alarm_o) else $error("alarm not set");
	a_irq_gated: assert property (
		alarm_irq_o == (power_alarm_o && $past(alarm_irq_enable_i, 3)))
		else $error("irq not alarm and enable");
	a_settings_hold: assert property (
		cs_n_i [*8] |-> $stable(loop_current_cap_o) && $stable(open_line_voltage_o)
		&& $stable(common_offset_voltage_o)) else $error("setting moved");
	c_audio: cover property ($rose(audio_power_o));
	c_ringing: cover property ($rose(ringing_drive_o));
	c_irq: cover property ($rose(alarm_irq_o));
endmodule : lfsc_top_chk

bind lfsc_top lfsc_top_chk chk_u (.*);

//--- verification/lfsc_line_model.sv
// line transistors: power builds while a staged fault meets a driven lead
// assumes the bench stages faults; slow_i picks a long thermal filter
`timescale 1ns/1ns
module lfsc_line_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// drives and fault staging
	input wire logic tip_drive_i,
	input wire logic ring_drive_i,
	input wire logic fault_i,
	input wire logic slow_i,
	output logic power_over_o
);
	logic [7:0] heat_reg;
	// no lead current means no dissipation, so opening the leads cools at once
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			heat_reg <= 8'h00;
		end else begin
			heat_reg <= (fault_i && (tip_drive_i || ring_drive_i)) ? heat_reg + 8'h01 : 8'h00;
		end
	end
	assign power_over_o = heat_reg > (slow_i ? 8'h20 : 8'h00);
endmodule : lfsc_line_model

//--- verification/test_linefeed_state_control.sv
// self-checking bench for the line feed state control block
// assumes the serial port is the only register path
`timescale 1ns/1ns
module test_linefeed_state_control;
	import lfsc_pkg::*;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, sclk = 1'b0, cs_n = 1'b1, mosi = 1'b0;
	logic fault = 1'b0, slow = 1'b0, aopen = 1'b0, irq_en = 1'b0, clr = 1'b0;
	logic miso, oe, over, alarm, irq, tip, ring, ringing, rev, audio;
	logic [2:0] cap;
	logic [5:0] olv, cov;
	lfsc_byte_t q;
	lfsc_addr_t ta [6] = '{7'h47, 7'h47, 7'h48, 7'h48, 7'h49, 7'h41};
	lfsc_byte_t tw [6] = '{8'hFF, 8'h05, 8'h3F, 8'hD5, 8'h2A, 8'h55};
	lfsc_byte_t tr [6] = '{8'h07, 8'h05, 8'h3F, 8'h15, 8'h2A, 8'h00};
	int n_fail = 0;
	int samples_checked = 0;
	wire logic [15:0] lines = {11'h000, tip, ring, ringing, rev, audio};
	wire logic [15:0] flags = {14'h0000, alarm, irq};
	wire logic [15:0] feed = {1'b0, cap, olv, cov};

	lfsc_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe), .power_over_i(over),
		.auto_open_enable_i(aopen), .alarm_irq_enable_i(irq_en), .alarm_clear_i(clr),
		.power_alarm_o(alarm), .alarm_irq_o(irq), .tip_drive_o(tip), .ring_drive_o(ring),
		.ringing_drive_o(ringing), .reverse_polarity_o(rev), .audio_power_o(audio),
		.loop_current_cap_o(cap), .open_line_voltage_o(olv), .common_offset_voltage_o(cov));
	lfsc_line_model model_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tip_drive_i(tip),
		.ring_drive_i(ring), .fault_i(fault), .slow_i(slow), .power_over_o(over));

	initial begin
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : tick

	// one frame, bit 7 of the command set for a read; sclk phases are 6 clocks
	task automatic xfer(input lfsc_byte_t c, input lfsc_byte_t d);
		logic [15:0] w;
		w = {c, d};
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = w[i];
			tick(6);
			if (i < 8) q[i] = miso;
			if (i == 0) chk({15'h0000, oe}, 16'h0001);
			sclk = 1'b1;
			tick(6);
			sclk = 1'b0;
		end
		tick(8);
		cs_n = 1'b1;
		mosi = ~mosi;
		tick(8);
	endtask : xfer

	function automatic logic [15:0] drv(input logic [2:0] s);
		drv = {11'h000, s != 3'h0 && s != 3'h3, s != 3'h0 && s != 3'h7, s == 3'h4,
			s == 3'h5 || s == 3'h6, s == 3'h2 || s == 3'h6};
	endfunction : drv

	initial begin
		tick(16);
		rst_n_i = 1'b1;
		tick(10);
		chk(lines, 16'h0000);
		chk(feed, 16'h0802);
		chk({15'h0000, oe}, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			xfer({1'b0, ta[i]}, tw[i]);
			xfer({1'b1, ta[i]}, 8'h00);
			chk({8'h00, q}, {8'h00, tr[i]});
		end
		chk(feed, 16'h556A);
		for (int s = 7; s >= 0; s--) begin
			xfer(8'h40, 8'(s));
			chk(lines, drv(3'(s)));
			xfer(8'hC0, 8'h00);
			chk({8'h00, q}, 16'(s * 17));
		end
		xfer(8'h40, 8'hF9);
		xfer(8'hC0, 8'h00);
		chk({8'h00, q}, 16'h0011);
		fault = 1'b1;
		tick(12);
		chk(flags, 16'h0002);
		chk(lines, drv(3'h1));
		irq_en = 1'b1;
		tick(6);
		chk(flags, 16'h0003);
		fault = 1'b0;
		clr = 1'b1;
		tick(8);
		clr = 1'b0;
		chk(flags, 16'h0000);
		aopen = 1'b1;
		slow = 1'b1;
		fault = 1'b1;
		tick(60);
		chk(lines, 16'h0000);
		fault = 1'b0;
		xfer(8'hC0, 8'h00);
		chk({8'h00, q}, 16'h0000);
		xfer(8'h40, 8'h05);
		chk(lines, drv(3'h5));
		xfer(8'hC7, 8'h00);
		chk({8'h00, q}, 16'h0005);
		report_and_stop();
	end

	initial begin
		tick(20000);
		n_fail++;
		$display("mismatch at %0t: run hung", $time);
		report_and_stop();
	end
endmodule : test_linefeed_state_control
